// File: design/counter_latch_consts.svh
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: 32-bit APB data, byte addresses on paddr[7:0]
// Notes:   definitions only, no logic
`ifndef COUNTER_LATCH_CONSTS_SVH
`define COUNTER_LATCH_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_CONFIG      8'h04
`define OFS_LOAD        8'h08
`define OFS_CMP_A       8'h0C
`define OFS_CMP_B       8'h10
`define OFS_COUNT       8'h14
`define OFS_REPORT      8'h18
`define OFS_LIVE        8'h1C
`define OFS_STATUS      8'h20

// ----------------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------------
`define CTRL_GATE       0
`define CTRL_SYNC_EN    1
`define CTRL_CLEAR      2
`define CTRL_FORCE_A    3
`define CTRL_FORCE_B    4
`define CTRL_EN_A       5
`define CTRL_EN_B       6
`define CTRL_W          7

// ----------------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------------
`define CFG_AUX_LO      0
`define CFG_PERIODIC    2
`define CFG_INTERRUPT   3
`define CFG_DIR_LO      4
`define CFG_FUNC_A_LO   8
`define CFG_FUNC_B_LO   10
`define CFG_PW_A_LO     12
`define CFG_PW_B_LO     20
`define CFG_PW_W        8

// ----------------------------------------------------------------------
// status register bits
// ----------------------------------------------------------------------
`define STS_AUX         0
`define STS_SYNC        1
`define STS_OUT_A       2
`define STS_OUT_B       3
`define STS_CMP_A       4
`define STS_CMP_B       5
`define STS_GATE        6

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define RST_WORD        32'h0000_0000
`define RST_CTRL        7'h00
`define PULSE_STEP_MS   2
`define CLK_KHZ         40000
`define PRE_W           17

`endif

// File: design/counter_latch_pkg.sv
// Purpose: types shared by the latch, sync and compare logic
// Assumes: field codes follow declaration order of each enum
// Notes:   no constants here, those live in the consts header
package counter_latch_pkg;

  // function of the auxiliary input
  typedef enum logic [1:0] {
    AUX_PLAIN,
    AUX_RETRIG,
    AUX_LATCH,
    AUX_SYNC
  } aux_func_e;

  // behaviour of each switch output
  typedef enum logic [1:0] {
    OUT_DIRECT,
    OUT_GE,
    OUT_LE,
    OUT_PULSE
  } out_func_e;

  // main count direction
  typedef enum logic [1:0] {
    DIR_NONE,
    DIR_UP,
    DIR_DOWN,
    DIR_SPARE
  } dir_e;

endpackage : counter_latch_pkg

// File: design/counter_latch_sync_compare.sv
// Purpose: latch, retrigger, sync and compare outputs of an up/down counter
// Assumes: count strobes come from logic on pclk; aux_input_pin is a pin
// Notes:   registers over APB, answer one cycle into the access phase
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "counter_latch_consts.svh"

module counter_latch_sync_compare #(
  parameter int STEP_CYCLES = `PULSE_STEP_MS * `CLK_KHZ  // cycles per 2 ms
) (
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // count strobes from the counting core
  input  wire logic        count_up_pulse,
  input  wire logic        count_down_pulse,
  // auxiliary input pin
  input  wire logic        aux_input_pin,
  // real switch output
  output logic             physical_switch_output
);

  // ----------------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------------
  logic [31:0] prdata_q, prdata_d;         // read data
  logic        pready_q, pready_d;         // access-phase answer
  logic        pslverr_q, pslverr_d;       // unmapped address
  logic [`CTRL_W-1:0] ctrl_q, ctrl_d;      // control bits
  logic [31:0] cfg_q, cfg_d;               // configuration
  logic [31:0] load_q, load_d;             // load value
  logic [31:0] cmp_q [2];                  // comparison values
  logic [31:0] cmp_d [2];
  logic [31:0] count_q, count_d;           // live count
  logic [31:0] latch_q, latch_d;           // captured count
  logic        gate_q, gate_d;             // program gate open
  logic        gate_prev_q;                // gate bit last cycle
  logic        opened_q, opened_d;         // gate has opened once
  logic        armed_q, armed_d;           // retrigger armed
  logic        sync_used_q, sync_used_d;   // once-only sync spent
  logic        sync_done_q, sync_done_d;   // sticky sync done
  logic        aux_s1_q, aux_s2_q;         // pin synchroniser
  logic        aux_prev_q;                 // last synchronised level
  logic [1:0]  reach_q, reach_d;           // step landed on compare
  logic [1:0]  out_q, out_d;               // output states
  logic [1:0]  flag_q, flag_d;             // sticky compare flags
  logic        phys_q;                     // physical pin copy

  // ----------------------------------------------------------------------
  // decoded configuration
  // ----------------------------------------------------------------------
  counter_latch_pkg::aux_func_e aux_func;
  counter_latch_pkg::dir_e      main_dir;
  logic        aux_edge;
  logic        gate_rise;
  logic        wr_go;
  logic        step_up, step_dn;
  logic [31:0] count_step;

  assign aux_func = counter_latch_pkg::aux_func_e'(cfg_q[`CFG_AUX_LO +: 2]);
  assign main_dir = counter_latch_pkg::dir_e'(cfg_q[`CFG_DIR_LO +: 2]);
  // edge acts once: compared against the previous sample only
  assign aux_edge  = aux_s2_q & ~aux_prev_q;
  assign gate_rise = ctrl_q[`CTRL_GATE] & ~gate_prev_q;
  assign wr_go     = psel & penable & pready_q & pwrite & ~pslverr_q;
  assign step_up   = gate_q & count_up_pulse & ~count_down_pulse;
  assign step_dn   = gate_q & count_down_pulse & ~count_up_pulse;

  // mapped-address check, used by the error path only
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `OFS_CTRL)  || (a == `OFS_CONFIG) ||
                (a == `OFS_LOAD)  || (a == `OFS_CMP_A)  ||
                (a == `OFS_CMP_B) || (a == `OFS_COUNT)  ||
                (a == `OFS_REPORT) || (a == `OFS_LIVE)  ||
                (a == `OFS_STATUS);
  endfunction : is_mapped

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  // answer registered so every bus output comes from a flop
  always_comb begin
    logic [31:0] rd;
    logic [31:0] sts;
    rd  = `RST_WORD;
    sts = `RST_WORD;
    sts[`STS_AUX]   = aux_s2_q;
    sts[`STS_SYNC]  = sync_done_q;
    sts[`STS_OUT_A] = out_q[0];
    sts[`STS_OUT_B] = out_q[1];
    sts[`STS_CMP_A] = flag_q[0];
    sts[`STS_CMP_B] = flag_q[1];
    sts[`STS_GATE]  = gate_q;
    if (paddr == `OFS_CTRL) begin
      rd[`CTRL_W-1:0] = ctrl_q;
    end else if (paddr == `OFS_CONFIG) begin
      rd = cfg_q;
    end else if (paddr == `OFS_LOAD) begin
      rd = load_q;
    end else if (paddr == `OFS_CMP_A) begin
      rd = cmp_q[0];
    end else if (paddr == `OFS_CMP_B) begin
      rd = cmp_q[1];
    end else if (paddr == `OFS_COUNT || paddr == `OFS_LIVE) begin
      rd = count_q;
    end else if (paddr == `OFS_REPORT) begin
      // latch modes report the capture; latch takes every edge, retrigger only once armed
      rd = (aux_func == counter_latch_pkg::AUX_RETRIG ||
            aux_func == counter_latch_pkg::AUX_LATCH) ?
           latch_q : count_q;
    end else if (paddr == `OFS_STATUS) begin
      rd = sts;
    end
    pready_d  = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~is_mapped(paddr);
    prdata_d  = (pready_d & ~pwrite) ? rd : `RST_WORD;
  end

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= `RST_WORD;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------------
  // counter, latch, retrigger and sync
  // ----------------------------------------------------------------------
  always_comb begin
    logic retrig_fire;
    logic sync_fire;
    ctrl_d      = ctrl_q;
    cfg_d       = cfg_q;
    load_d      = load_q;
    cmp_d       = cmp_q;
    count_d     = count_q;
    latch_d     = latch_q;
    count_step  = count_q;
    // gate opens on a rise of its bit, closes when bit clears
    gate_d      = ctrl_q[`CTRL_GATE] & (gate_q | gate_rise);
    opened_d    = opened_q | gate_rise;
    // retrigger waits for the gate to have opened first
    armed_d     = armed_q | gate_q;
    retrig_fire = (aux_func == counter_latch_pkg::AUX_RETRIG) &
                  armed_q & aux_edge;
    sync_fire   = (aux_func == counter_latch_pkg::AUX_SYNC) & gate_q &
                  ctrl_q[`CTRL_SYNC_EN] & aux_edge &
                  (cfg_q[`CFG_PERIODIC] | ~sync_used_q);
    // once-only rearms when the enable bit is dropped
    sync_used_d = ctrl_q[`CTRL_SYNC_EN] & (sync_used_q | sync_fire);
    // set wins over the clear
    sync_done_d = sync_fire |
                  (sync_done_q & ~ctrl_q[`CTRL_CLEAR]);
    if (step_up) begin
      count_step = count_q + 32'h0000_0001;
    end else if (step_dn) begin
      count_step = count_q - 32'h0000_0001;
    end
    // capture the count present at the edge
    if (retrig_fire) begin
      latch_d = count_q;
    end else if ((aux_func == counter_latch_pkg::AUX_LATCH) & aux_edge) begin
      latch_d = count_q;
    end
    // count source, direct load first
    if (wr_go && paddr == `OFS_COUNT) begin
      count_d = pwdata;
    end else if (retrig_fire || sync_fire) begin
      count_d = load_q;
    end else if (gate_rise && (!cfg_q[`CFG_INTERRUPT] || !opened_q) &&
                 aux_func != counter_latch_pkg::AUX_RETRIG) begin
      count_d = load_q;
    end else begin
      count_d = count_step;
    end
    // a step landing on a comparison value, per direction
    for (int i = 0; i < 2; i++) begin
      reach_d[i] = (count_step == cmp_q[i]) &
                   ((step_up & (main_dir != counter_latch_pkg::DIR_DOWN)) |
                    (step_dn & (main_dir != counter_latch_pkg::DIR_UP)));
    end
    // software register writes
    if (wr_go) begin
      if (paddr == `OFS_CTRL) begin
        ctrl_d = pwdata[`CTRL_W-1:0];
      end else if (paddr == `OFS_CONFIG) begin
        cfg_d = pwdata;
      end else if (paddr == `OFS_LOAD) begin
        load_d = pwdata;
      end else if (paddr == `OFS_CMP_A) begin
        cmp_d[0] = pwdata;
      end else if (paddr == `OFS_CMP_B) begin
        cmp_d[1] = pwdata;
      end
    end
  end

  // counter group flops; reset values give a zero count and capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= `RST_CTRL;
      cfg_q       <= `RST_WORD;
      load_q      <= `RST_WORD;
      cmp_q       <= '{`RST_WORD, `RST_WORD};
      count_q     <= `RST_WORD;
      latch_q     <= `RST_WORD;
      gate_q      <= 1'b0;
      gate_prev_q <= 1'b0;
      opened_q    <= 1'b0;
      armed_q     <= 1'b0;
      sync_used_q <= 1'b0;
      sync_done_q <= 1'b0;
      aux_s1_q    <= 1'b0;
      aux_s2_q    <= 1'b0;
      aux_prev_q  <= 1'b0;
      reach_q     <= 2'h0;
    end else if (ce) begin
      ctrl_q      <= ctrl_d;
      cfg_q       <= cfg_d;
      load_q      <= load_d;
      cmp_q       <= cmp_d;
      count_q     <= count_d;
      latch_q     <= latch_d;
      gate_q      <= gate_d;
      gate_prev_q <= ctrl_q[`CTRL_GATE];
      opened_q    <= opened_d;
      armed_q     <= armed_d;
      sync_used_q <= sync_used_d;
      sync_done_q <= sync_done_d;
      aux_s1_q    <= aux_input_pin;
      aux_s2_q    <= aux_s1_q;
      aux_prev_q  <= aux_s2_q;
      reach_q     <= reach_d;
    end
  end

  // ----------------------------------------------------------------------
  // compare outputs, index 0 real, index 1 virtual
  // ----------------------------------------------------------------------
  generate
    for (genvar g = 0; g < 2; g++) begin : g_out
      counter_latch_pkg::out_func_e fn;
      logic [`CFG_PW_W-1:0] pw;
      logic                 en, frc;
      logic                 forced_q, forced_d;
      logic                 frc_prev_q;
      logic                 hold_q, hold_d;
      logic                 busy_q, busy_d;
      logic [`PRE_W-1:0]    pre_q, pre_d;
      logic [`CFG_PW_W-1:0] units_q, units_d;

      // function read live from config, so a change acts at once
      assign fn  = counter_latch_pkg::out_func_e'(
                     cfg_q[`CFG_FUNC_A_LO + 2*g +: 2]);
      assign pw  = cfg_q[`CFG_PW_A_LO + `CFG_PW_W*g +: `CFG_PW_W];
      assign en  = ctrl_q[`CTRL_EN_A + g];
      assign frc = ctrl_q[`CTRL_FORCE_A + g];

      // next output, timer and flag for this output
      always_comb begin
        logic ge, le, f_rise, f_fall, start, cond_hold, set;
        ge      = $signed(count_q) >= $signed(cmp_q[g]);
        le      = $signed(count_q) <= $signed(cmp_q[g]);
        f_rise  = frc & ~frc_prev_q;
        f_fall  = ~frc & frc_prev_q;
        // a forced level is only undone by the force bit itself
        forced_d = f_rise | (forced_q & ~f_fall);
        start   = (fn == counter_latch_pkg::OUT_PULSE) &&
                  (pw != '0) && ((en && reach_q[g]) || f_rise);
        busy_d  = busy_q;
        pre_d   = pre_q;
        units_d = units_q;
        if (start) begin
          busy_d  = 1'b1;
          pre_d   = '0;
          units_d = pw;
        end else if (busy_q) begin
          if (pre_q == `PRE_W'(STEP_CYCLES - 1)) begin
            pre_d   = '0;
            units_d = units_q - 8'h01;
            busy_d  = (units_q != 8'h01);
          end else begin
            pre_d = pre_q + `PRE_W'(1);
          end
        end
        // zero duration: hold while count sits on the value
        hold_d = (fn == counter_latch_pkg::OUT_PULSE) && (pw == '0) &&
                 ((en && reach_q[g]) ||
                  (hold_q && count_q == cmp_q[g]));
        if (fn != counter_latch_pkg::OUT_PULSE) begin
          busy_d = 1'b0;
        end
        case (fn)
          counter_latch_pkg::OUT_DIRECT: out_d[g] = en & frc;
          counter_latch_pkg::OUT_GE:     out_d[g] = forced_d | (en & ge);
          counter_latch_pkg::OUT_LE:     out_d[g] = forced_d | (en & le);
          default:                       out_d[g] = busy_d | hold_d;
        endcase
        // acknowledge refused while the cause still stands
        cond_hold = ((fn == counter_latch_pkg::OUT_GE) & en & ge) |
                    ((fn == counter_latch_pkg::OUT_LE) & en & le) |
                    ((fn == counter_latch_pkg::OUT_PULSE) & busy_q);
        set       = out_d[g] | (f_rise & ~en);
        flag_d[g] = set |
                    (flag_q[g] & ~(ctrl_q[`CTRL_CLEAR] & ~cond_hold));
      end

      // output group flops
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          forced_q   <= 1'b0;
          frc_prev_q <= 1'b0;
          hold_q     <= 1'b0;
          busy_q     <= 1'b0;
          pre_q      <= '0;
          units_q    <= '0;
          out_q[g]   <= 1'b0;
          flag_q[g]  <= 1'b0;
        end else if (ce) begin
          forced_q   <= forced_d;
          frc_prev_q <= frc;
          hold_q     <= hold_d;
          busy_q     <= busy_d;
          pre_q      <= pre_d;
          units_q    <= units_d;
          out_q[g]   <= out_d[g];
          flag_q[g]  <= flag_d[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // pin copy kept in its own flop so the port is a flop output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phys_q <= 1'b0;
    end else if (ce) begin
      phys_q <= out_d[0];
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign physical_switch_output = phys_q;

endmodule : counter_latch_sync_compare

// File: testbench/count_source.sv
// Purpose: counting core and pin model beside the block
// Assumes: strobes one cycle wide with a gap cycle
// Notes:   aux pin follows the bench request at once, like a pin
`timescale 1ns/1ps
module count_source (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // request
  input wire logic       go,
  input wire logic       down,
  input wire logic [7:0] n,
  input wire logic       aux_req,
  // far side
  output logic           count_up_pulse,
  output logic           count_down_pulse,
  output logic           aux_input_pin,
  output logic           busy
);
  logic [8:0] left_q;  // half-steps remaining
  // strobe on odd counts so strobes never touch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q           <= 9'h000;
      count_up_pulse   <= 1'b0;
      count_down_pulse <= 1'b0;
    end else begin
      left_q           <= go ? {n, 1'b0} : (left_q != 0 ? left_q - 1 : 0);
      count_up_pulse   <= left_q[0] & !down;
      count_down_pulse <= left_q[0] & down;
    end
  end
  assign busy          = go | (left_q != 0) | count_up_pulse;
  assign aux_input_pin = aux_req;  // raw async level
endmodule : count_source

// File: testbench/counter_latch_checker.sv
// Purpose: port-level checks of the apb answer and output freeze
// Assumes: one clock domain, reset presetn active low
// Notes:   bound to the top module below
`timescale 1ns/1ps
module counter_latch_checker (
  // clock, reset, enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // real output
  input wire logic        physical_switch_output
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // exactly one wait state after access starts
  property p_wait; $rose(penable) && psel |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  // answer stands one cycle only
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held");
  // error only with the answer
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray slverr");
  // read data quiet outside the answer
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("prdata idle");
  // writes return no data
  property p_wrz; pready && pwrite |-> prdata == 32'h0; endproperty
  a_wrz: assert property (p_wrz) else $error("prdata write");
  // holes above the map are refused
  property p_unm; pready && paddr > 8'h20 |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("no slverr");
  // mapped words are accepted
  property p_map;
    pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("bad slverr");
  // a stopped clock enable freezes the pin
  property p_frz; !ce |=> $stable(physical_switch_output); endproperty
  a_frz: assert property (p_frz) else $error("pin moved");
endmodule : counter_latch_checker

bind counter_latch_sync_compare counter_latch_checker u_counter_latch_checker (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .physical_switch_output(physical_switch_output));

// File: testbench/testbench.sv
// Purpose: apb sequences over latch, sync and compare behaviour
// Assumes: STEP_CYCLES 10, so one duration unit is 10 cycles
// Notes:   counts are fed by count_source between reads
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, ce, psel, penable, pwrite, go, down, aux_req;
  logic [7:0]  paddr, n;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, up_p, dn_p, aux_pin, busy, pin, err;
  int fail_count, compares, cyc, w, hi_cnt;
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  counter_latch_sync_compare #(.STEP_CYCLES(10)) u_counter_latch_sync_compare (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_up_pulse(up_p), .count_down_pulse(dn_p),
    .aux_input_pin(aux_pin), .physical_switch_output(pin));
  count_source u_count_source (.pclk(pclk), .presetn(presetn), .go(go),
    .down(down), .n(n), .aux_req(aux_req), .count_up_pulse(up_p),
    .count_down_pulse(dn_p), .aux_input_pin(aux_pin), .busy(busy));
  // ----
  // tasks
  // ----
  task end_of_test;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task chk(input string s, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (k == 50) fail_count++;
    rdat = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e,
          input logic [31:0] m = 32'hFFFFFFFF);
    xfer(a, 0, 32'h0);
    chk($sformatf("reg %h", a), e, rdat & m);
  endtask : rd
  // k strobes up or down, wait for the model to finish
  task pulses(input logic [7:0] k, input logic dn);
    int t;
    t = 0;
    @(posedge pclk);
    go <= 1; n <= k; down <= dn;
    @(posedge pclk);
    go <= 0;
    while (busy !== 1'b0 && t++ < 600) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask : pulses
  task edge_aux;
    @(posedge pclk) aux_req <= 1;
    repeat (8) @(posedge pclk);
    aux_req <= 0;
    repeat (8) @(posedge pclk);
  endtask : edge_aux
  // edges at which the pin stood high, for the pulse width
  always @(posedge pclk) if (pin === 1'b1) hi_cnt++;
  always @(posedge pclk) if (++cyc == 30000) begin
    fail_count++;  // hang cut short
    end_of_test();
  end
  // ----
  // sequence
  // ----
  initial begin
    {presetn, psel, penable, pwrite, go, down, aux_req} = 0;
    {paddr, n, pwdata, fail_count, compares, cyc} = 0;
    ce = 1;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    for (int a = 0; a <= 32; a += 4) rd(a[7:0], 32'h0);
    rd(8'h24, 32'h0);
    chk("slverr", 1, err);
    wr(8'h04, 32'h2); wr(8'h08, 32'h5); wr(8'h00, 32'h1);
    pulses(3, 0); pulses(1, 1); pulses(1, 0);
    rd(8'h1C, 32'h8);
    edge_aux();
    rd(8'h18, 32'h8);
    rd(8'h1C, 32'h8);
    wr(8'h14, 32'h64);
    rd(8'h18, 32'h8);
    wr(8'h04, 32'h1); edge_aux();
    rd(8'h18, 32'h64);
    rd(8'h1C, 32'h5);
    pulses(2, 0); wr(8'h00, 32'h0); pulses(2, 0); wr(8'h00, 32'h1);
    pulses(1, 0);
    rd(8'h1C, 32'h8);
    wr(8'h00, 32'h0); edge_aux();
    rd(8'h18, 32'h8);
    wr(8'h00, 32'h1); wr(8'h04, 32'h3); wr(8'h14, 32'h32); edge_aux();
    rd(8'h1C, 32'h32);
    wr(8'h00, 32'h3); edge_aux();
    rd(8'h1C, 32'h5);
    rd(8'h20, 32'h2, 32'h2);
    wr(8'h14, 32'h32); aux_req <= 1; repeat (8) @(posedge pclk);
    rd(8'h20, 32'h1, 32'h1);
    aux_req <= 0;
    rd(8'h1C, 32'h32);
    wr(8'h00, 32'h7); wr(8'h00, 32'h3);
    rd(8'h20, 32'h0, 32'h2);
    wr(8'h04, 32'h7); wr(8'h00, 32'h1); wr(8'h00, 32'h3);
    wr(8'h14, 32'h32); edge_aux(); wr(8'h14, 32'h32); edge_aux();
    rd(8'h1C, 32'h5);
    wr(8'h04, 32'h100); wr(8'h0C, 32'hA); wr(8'h00, 32'h21);
    wr(8'h14, 32'h9); pulses(1, 0);
    chk("pin ge", 1, pin);
    wr(8'h00, 32'h25); wr(8'h00, 32'h21);
    rd(8'h20, 32'h14, 32'h14);
    wr(8'h04, 32'h200); pulses(1, 0);
    chk("pin le", 0, pin);
    wr(8'h04, 32'h2300); wr(8'h14, 32'h9); hi_cnt = 0; pulses(1, 0);
    w = 1;
    while (pin === 1'b1 && w < 100) begin
      @(posedge pclk);
      w++;
    end
    repeat (2) @(posedge pclk);
    chk("width", 20, hi_cnt);
    wr(8'h04, 32'h2310); wr(8'h14, 32'hB); pulses(1, 1);
    chk("pin dir", 0, pin);
    wr(8'h04, 32'h300); wr(8'h14, 32'h9); pulses(1, 0);
    repeat (40) @(posedge pclk);
    chk("pin hold", 1, pin);
    ce <= 0; repeat (3) @(posedge pclk); ce <= 1;
    pulses(1, 0);
    chk("pin left", 0, pin);
    wr(8'h04, 32'h0); wr(8'h00, 32'h29);
    rd(8'h20, 32'h4, 32'h4);
    chk("pin dir", 1, pin);
    wr(8'h00, 32'h5); wr(8'h00, 32'h1); wr(8'h00, 32'h9);
    rd(8'h20, 32'h10, 32'h14);
    wr(8'h00, 32'h51);
    rd(8'h20, 32'h28, 32'h28);
    end_of_test();
  end
endmodule : testbench
